// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "utsm_defines.vh"
module tb_top;
  localparam integer N    = 20;
  localparam [7:0]   SKIP = 8'h01;
  reg         clk_in     = 1'b0;
  reg         arst_n_in  = 1'b0;
  reg  [1:0]  mode_in    = 2'h0;
  reg         start_in   = 1'b0;
  reg  [9:0]  ext_len_in = 10'h008;
  reg  [7:0]  win_len_in = 8'h10;
  reg  [9:0]  advance_in = 10'h020;
  reg  [15:0] word_in    = 16'h0000;
  reg         clr        = 1'b0;
  reg         slow       = 1'b0;
  reg         sync_run   = 1'b0;
  integer     got_cnt    = 0;
  integer     errors     = 0;
  integer     compares   = 0;
  wire [1:0]  prbs_in, point_out;
  wire [11:0] tone_out;
  wire [9:0]  sym_ext_out, sym_adv_out;
  wire [12:0] sym_len_out;
  wire [7:0]  sym_win_out;
  wire        prbs_take_out, prbs_skip_out, point_valid_out, point_ready_in;
  wire        sym_start_out, busy_out, data_mode_out, rot_off_out;
  always #4 clk_in = ~clk_in;
  utsm_mapper u_dut (.clk_in, .arst_n_in, .mode_in, .start_in, .tone_count_in(12'h014), .ext_len_in,
    .win_len_in, .advance_in, .word_in, .prbs_in, .prbs_take_out, .prbs_skip_out, .point_out, .tone_out,
    .point_valid_out, .point_ready_in, .sym_start_out, .sym_ext_out, .sym_len_out, .sym_win_out,
    .sym_adv_out, .busy_out, .data_mode_out, .rot_off_out);
  utsm_far_model #(.SKIP(SKIP)) u_far (.clk_in, .clr_in(clr), .slow_in(slow), .take_in(prbs_take_out),
    .skip_in(prbs_skip_out), .prbs_out(prbs_in), .ready_out(point_ready_in));
  // ----
  // Checking
  // ----
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Quarter turns step through 00 01 11 10, so rotate in Gray index space
  function [1:0] exp_pt(input integer i);
    integer s, k, m, r;
    reg [1:0] p;
    begin
      s = i / N;
      k = i % N;
      m = k % 10;
      r = (s * (N + SKIP) + k) % 4;
      if (sync_run)
        p = (s < 5 || s >= 10) ? 2'h3 : 2'h0;
      else if (m == 0 || m == 5)
        p = 2'h0;
      else
        p = word_in[2 * (m - 1 - (m > 5)) +: 2];
      p = {p[1], p[1] ^ p[0]} + r[1:0];
      exp_pt = {p[1], p[1] ^ p[0]};
    end
  endfunction
  always @(posedge clk_in)
  begin
    if (point_valid_out === 1'b1 && point_ready_in === 1'b1)
    begin
      chk({14'h0000, point_out}, {14'h0000, exp_pt(got_cnt)});
      chk({4'h0, tone_out}, 16'(got_cnt % N));
      got_cnt = got_cnt + 1;
    end
  end
  // ----
  // Scenarios
  // ----
  task kick(input [1:0] m);
    begin
      got_cnt = 0;
      clr = 1'b1;
      mode_in = m;
      start_in = 1'b1;
      @(posedge clk_in);
      #1;
      clr = 1'b0;
      start_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (busy_out !== 1'b0 && n < 5000)
      begin
        @(posedge clk_in);
        n = n + 1;
      end
      if (n >= 5000)
      begin
        errors = errors + 1;
        report_and_stop;
      end
      repeat (16) @(posedge clk_in);
      #1;
    end
  endtask
  task run_probe(input [15:0] w, input sl);
    begin
      sync_run = 1'b0;
      word_in = w;
      slow = sl;
      kick(`UTSM_MODE_PROBE);
      repeat (30) @(posedge clk_in);
      #1;
      ext_len_in = ext_len_in + 10'h004;
      repeat (70) @(posedge clk_in);
      #1;
      mode_in = `UTSM_MODE_IDLE;
      wait_idle;
      chk(16'(got_cnt % N), 16'h0000);
      chk(16'(got_cnt >= 2 * N), 16'h0001);
      chk({6'h00, sym_ext_out}, {6'h00, ext_len_in});
      chk({3'h0, sym_len_out}, 16'(N) + {6'h00, ext_len_in});
      chk({8'h00, sym_win_out}, {8'h00, win_len_in});
      chk({6'h00, sym_adv_out}, {6'h00, advance_in});
    end
  endtask
  task run_sync;
    begin
      sync_run = 1'b1;
      slow = 1'b1;
      kick(`UTSM_MODE_SYNC);
      start_in = 1'b1;
      @(posedge clk_in);
      #1;
      start_in = 1'b0;
      wait_idle;
      chk(16'(got_cnt), 16'(15 * N));
      chk({15'h0000, data_mode_out}, 16'h0001);
      chk({15'h0000, rot_off_out}, 16'h0001);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    run_probe(16'h1be4, 1'b0);
    win_len_in = 8'h2c;
    advance_in = 10'h13a;
    run_probe(16'h4e27, 1'b1);
    run_sync;
    report_and_stop;
  end
endmodule // tb_top

// *** dv/utsm_far_model.sv ***
`timescale 1ns/100ps
// ----
// Far side: point sink and rotation bit source
// ----
module utsm_far_model
#(
  parameter [7:0] SKIP = 8'h01
)
(
  input  wire       clk_in,   // Clock
  input  wire       clr_in,   // Restart bits
  input  wire       slow_in,  // Stall every other cycle
  input  wire       take_in,  // Next pair
  input  wire       skip_in,  // Skip between symbols
  output wire [1:0] prbs_out, // Current pair
  output reg        ready_out // Sink ready
);
  reg  [7:0] cnt_reg;
  wire [7:0] cnt_now;
  // A take or skip raised this cycle is already applied to the pair on
  // show, since the mapper needs a fresh pair on every back-to-back tone
  assign cnt_now  = cnt_reg + {7'h00, take_in} + (skip_in ? SKIP : 8'h00);
  assign prbs_out = cnt_now[1:0];
  initial ready_out = 1'b1;
  // Only the bench restarts the source, never a symbol edge
  always @(posedge clk_in)
  begin
    if (clr_in)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_now;
    ready_out <= !slow_in || !ready_out;
  end
endmodule // utsm_far_model

// *** dv/utsm_mapper_monitor.sv ***
`timescale 1ns/100ps
`include "utsm_defines.vh"
module utsm_mapper_checker
#(
  parameter TONE_W = 12,
  parameter CE_W   = 10
)
(
  input wire              clk_in,          // Clock
  input wire              arst_n_in,       // Reset
  input wire [1:0]        mode_in,         // Mode
  input wire              start_in,        // Start
  input wire [TONE_W-1:0] tone_count_in,   // N
  input wire              point_ready_in,  // Ready
  input wire              prbs_take_out,   // Take
  input wire              prbs_skip_out,   // Skip
  input wire [1:0]        point_out,       // Point
  input wire              point_valid_out, // Valid
  input wire              sym_start_out,   // Symbol start
  input wire [CE_W-1:0]   sym_ext_out,     // Prefix
  input wire [TONE_W:0]   sym_len_out,     // Length
  input wire              busy_out,        // Busy
  input wire              data_mode_out,   // Data mode
  input wire              rot_off_out      // Rotation off
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_stall;
    point_valid_out && !point_ready_in;
  endsequence
  sequence s_begin;
    start_in && !busy_out && (mode_in == `UTSM_MODE_PROBE || mode_in == `UTSM_MODE_SYNC);
  endsequence
  a_point_hold: assert property (s_stall |=> point_valid_out && $stable(point_out))
    else $error("stalled point changed");
  a_start_answer: assert property (s_begin |-> ##3 point_valid_out)
    else $error("no point three cycles after start");
  a_start_busy: assert property (s_begin |=> busy_out)
    else $error("start not taken");
  a_ext_boundary: assert property (!sym_start_out |-> $stable(sym_ext_out))
    else $error("prefix changed inside a symbol");
  a_len_sum: assert property (sym_start_out |-> sym_len_out == tone_count_in + sym_ext_out)
    else $error("symbol length wrong");
  a_rot_quiet: assert property (rot_off_out ##1 rot_off_out |-> !prbs_take_out && !prbs_skip_out)
    else $error("random bits used with rotation off");
  a_rot_sticky: assert property (rot_off_out && !start_in && !$past(start_in) |=> rot_off_out)
    else $error("rotation re-enabled");
  a_data_rot: assert property ($rose(data_mode_out) |-> ##[0:1] rot_off_out)
    else $error("data mode without rotation off");
endmodule // utsm_mapper_checker
bind utsm_mapper utsm_mapper_checker #(.TONE_W(TONE_W), .CE_W(CE_W)) u_chk (.clk_in, .arst_n_in, .mode_in,
  .start_in, .tone_count_in, .point_ready_in, .prbs_take_out, .prbs_skip_out, .point_out, .point_valid_out,
  .sym_start_out, .sym_ext_out, .sym_len_out, .busy_out, .data_mode_out, .rot_off_out);

// *** pkg/utsm_defines.vh ***
`ifndef UTSM_DEFINES_VH
`define UTSM_DEFINES_VH
// Signal modes
`define UTSM_MODE_IDLE    2'h0
`define UTSM_MODE_PROBE   2'h1
`define UTSM_MODE_SYNC    2'h2
// Sync signal layout in symbols
`define UTSM_SYNC_SYMBOLS 4'hf
`define UTSM_SYNC_EDGE    4'h5
// Constellation values
`define UTSM_POINT_ZERO   2'h0
`define UTSM_POINT_ONE    2'h3
// Tone period of the probe pattern
`define UTSM_TONE_PERIOD  4'ha
`define UTSM_TONE_HALF    4'h5
// Output FIFO depth
`define UTSM_FIFO_DEPTH   4
`endif

// *** rtl/utsm_fifo.v ***
`timescale 1ns/100ps
module utsm_fifo
#(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             clk_in,     // Clock
  input  wire             arst_n_in,  // Async reset, active low
  input  wire [WIDTH-1:0] wdata_in,   // Write data
  input  wire             wvalid_in,  // Write valid
  output wire             wready_out, // Not full
  output wire [WIDTH-1:0] rdata_out,  // Read data
  output wire             rvalid_out, // Not empty
  input  wire             rready_in   // Read ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wptr_reg;
  reg [AW-1:0]    rptr_reg;
  reg [AW:0]      cnt_reg;
  wire            do_wr;
  wire            do_rd;

  assign wready_out = (cnt_reg != DEPTH);
  assign rvalid_out = (cnt_reg != 0);
  assign rdata_out  = mem_reg[rptr_reg];
  assign do_wr      = wvalid_in & wready_out;
  assign do_rd      = rready_in & rvalid_out;

  always @(posedge clk_in)
  begin
    if (do_wr)
      mem_reg[wptr_reg] <= wdata_in;
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wptr_reg <= (wptr_reg == DEPTH-1) ? {AW{1'b0}} : wptr_reg + 1'b1;
      if (do_rd)
        rptr_reg <= (rptr_reg == DEPTH-1) ? {AW{1'b0}} : rptr_reg + 1'b1;
      if (do_wr & ~do_rd)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_rd & ~do_wr)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule // utsm_fifo

// *** rtl/utsm_mapper.v ***
// Operation
// - Each probe and sync symbol spans N plus CE samples.
// - A new CE takes effect only at the next symbol boundary.
// - Probe uses every allowed tone, 4QAM, two bits per tone including DC.
// - Probe carries one 16-bit control word, repeated over the tone pattern.
// - Tones mod 10 equal 1..4 carry word bit pairs 0-1..6-7.
// - Tones mod 10 equal 6..9 carry word bit pairs 8-9..14-15.
// - Each point is rotated by a quarter-turn count from 2 random bits.
// - Probe rotation sequence continues across symbols without restart.
// - Random bits are skipped between symbols, count set with the generator.
// - Probe is sent with the timing advance given by the central side.
// - Probe symbols are windowed with the announced window length.
// - Sync signal lets both ends enter data mode together.
// - Sync signal lasts exactly 15 symbols, all allowed tones in 4QAM.
// - First five and last five sync symbols carry 11.
// - Middle five sync symbols carry 00 before rotation.
// - Sync rotation sequence continues across symbols without restart.
// - Scrambler runs free throughout the sync signal.
// - After sync, quadrant rotation is disabled for all later symbols until a new probe starts.
`timescale 1ns/100ps
`include "utsm_defines.vh"
module utsm_mapper
#(
  parameter TONE_W = 12,
  parameter CE_W   = 10,
  parameter WIN_W  = 8,
  parameter ADV_W  = 10
)
(
  input  wire              clk_in,           // 125 MHz clock
  input  wire              arst_n_in,        // Async reset, active low
  input  wire [1:0]        mode_in,          // Requested signal: idle, probe, sync
  input  wire              start_in,         // Pulse: begin the requested signal
  input  wire [TONE_W-1:0] tone_count_in,    // N: tones per symbol
  input  wire [CE_W-1:0]   ext_len_in,       // CE: cyclic extension samples
  input  wire [WIN_W-1:0]  win_len_in,       // Overall window length
  input  wire [ADV_W-1:0]  advance_in,       // Timing advance in samples
  input  wire [15:0]       word_in,          // Control-channel word
  input  wire [1:0]        prbs_in,          // Two fresh random bits
  output reg               prbs_take_out,    // Consume two random bits
  output reg               prbs_skip_out,    // Pulse: skip bits between symbols
  output reg  [1:0]        point_out,        // Rotated 4QAM point
  output reg  [TONE_W-1:0] tone_out,         // Tone index of point_out
  output reg               point_valid_out,  // Point valid
  input  wire              point_ready_in,   // Downstream ready
  output reg               sym_start_out,    // First tone of a symbol
  output reg  [CE_W-1:0]   sym_ext_out,      // Prefix sample count for the symbol
  output reg  [TONE_W:0]   sym_len_out,      // N+CE samples of the symbol
  output reg  [WIN_W-1:0]  sym_win_out,      // Window length for the symbol
  output reg  [ADV_W-1:0]  sym_adv_out,      // Timing advance for the symbol
  output reg               busy_out,         // Signal in progress
  output reg               data_mode_out,    // Sync sent: enter data mode
  output reg               rot_off_out       // Quadrant rotation disabled
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'b001;
  localparam ST_PROBE = 3'b010;
  localparam ST_SYNC  = 3'b100;

  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg  [TONE_W-1:0] tone_reg;
  reg  [3:0]        mod10_reg;
  reg  [3:0]        sym_reg;
  reg  [CE_W-1:0]   ext_reg;
  reg               rot_off_reg;
  reg  [TONE_W-1:0] n_reg;
  reg  [15:0]       word_reg;
  reg  [1:0]        base;
  reg  [1:0]        rot;
  wire              fifo_wready;
  wire [1:0]        fifo_point;
  wire [TONE_W-1:0] fifo_tone;
  wire              fifo_rvalid;
  wire              emit;
  wire              last_tone;
  wire              fifo_rd;
  wire              sym_load;

  assign emit      = (state_reg != ST_IDLE) & fifo_wready;
  // N of zero is a configuration error: the sequencer then walks the
  // whole tone range before it sees a last tone
  assign last_tone = (tone_reg == n_reg - 1'b1);
  assign sym_load  = (state_reg == ST_IDLE && state_next != ST_IDLE) |
                     (emit & last_tone);

  // ----------------------------------------------------------------
  // Constellation selection
  // ----------------------------------------------------------------
  always @*
  begin
    base = `UTSM_POINT_ZERO;
    if (state_reg == ST_SYNC)
    begin
      // Symbols 0-4 and 10-14 are the marker edges, the middle five carry zero
      if (sym_reg < `UTSM_SYNC_EDGE || sym_reg >= `UTSM_SYNC_SYMBOLS - `UTSM_SYNC_EDGE)
        base = `UTSM_POINT_ONE;
      else
        base = `UTSM_POINT_ZERO;
    end
    else
    begin
      case (mod10_reg)
        4'h1: base = word_reg[1:0];
        4'h2: base = word_reg[3:2];
        4'h3: base = word_reg[5:4];
        4'h4: base = word_reg[7:6];
        4'h6: base = word_reg[9:8];
        4'h7: base = word_reg[11:10];
        4'h8: base = word_reg[13:12];
        4'h9: base = word_reg[15:14];
        default: base = `UTSM_POINT_ZERO;
      endcase
    end
  end

  // Quarter-turn rotation: 00->01->11->10 Gray ring in the complex plane
  always @*
  begin
    rot = base;
    if (!rot_off_reg)
    begin
      case (prbs_in)
        2'h1: rot = {base[0], ~base[1]};
        2'h2: rot = ~base;
        2'h3: rot = {~base[0], base[1]};
        default: rot = base;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_in && mode_in == `UTSM_MODE_PROBE)
          state_next = ST_PROBE;
        else if (start_in && mode_in == `UTSM_MODE_SYNC)
          state_next = ST_SYNC;
      end
      ST_PROBE:
      begin
        if (emit && last_tone && mode_in != `UTSM_MODE_PROBE)
          state_next = ST_IDLE;
      end
      ST_SYNC:
      begin
        if (emit && last_tone && sym_reg == `UTSM_SYNC_SYMBOLS - 4'h1)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg     <= ST_IDLE;
      tone_reg      <= {TONE_W{1'b0}};
      mod10_reg     <= 4'h0;
      sym_reg       <= 4'h0;
      ext_reg       <= {CE_W{1'b0}};
      rot_off_reg   <= 1'b0;
      prbs_take_out <= 1'b0;
      prbs_skip_out <= 1'b0;
      sym_start_out <= 1'b0;
      sym_ext_out   <= {CE_W{1'b0}};
      sym_len_out   <= {(TONE_W+1){1'b0}};
      sym_win_out   <= {WIN_W{1'b0}};
      sym_adv_out   <= {ADV_W{1'b0}};
      busy_out      <= 1'b0;
      data_mode_out <= 1'b0;
      rot_off_out   <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      // The take lags the tone by one cycle, so the generator must already
      // show the following pair while a take is raised; tones leave back to
      // back and would otherwise reuse a pair
      prbs_take_out <= emit & ~rot_off_reg;
      prbs_skip_out <= emit & last_tone & ~rot_off_reg;
      sym_start_out <= emit & (tone_reg == {TONE_W{1'b0}});
      busy_out      <= (state_next != ST_IDLE);
      rot_off_out   <= rot_off_reg;
      if (state_reg == ST_IDLE && state_next != ST_IDLE)
      begin
        tone_reg  <= {TONE_W{1'b0}};
        mod10_reg <= 4'h0;
        sym_reg   <= 4'h0;
        ext_reg   <= ext_len_in;
        // Rotation returns only with a new probe; a repeated sync keeps it off
        if (state_next == ST_PROBE)
          rot_off_reg <= 1'b0;
        data_mode_out <= 1'b0;
      end
      else if (emit)
      begin
        if (tone_reg == {TONE_W{1'b0}})
        begin
          sym_ext_out <= ext_reg;
          sym_len_out <= {1'b0, n_reg} + {{(TONE_W+1-CE_W){1'b0}}, ext_reg};
          sym_win_out <= win_len_in;
          sym_adv_out <= advance_in;
        end
        if (last_tone)
        begin
          tone_reg  <= {TONE_W{1'b0}};
          mod10_reg <= 4'h0;
          sym_reg   <= sym_reg + 4'h1;
          ext_reg   <= ext_len_in;
          if (state_reg == ST_SYNC && sym_reg == `UTSM_SYNC_SYMBOLS - 4'h1)
          begin
            rot_off_reg   <= 1'b1;
            data_mode_out <= 1'b1;
          end
        end
        else
        begin
          tone_reg  <= tone_reg + 1'b1;
          mod10_reg <= (mod10_reg == `UTSM_TONE_PERIOD - 4'h1) ? 4'h0 : mod10_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-symbol capture
  // ----------------------------------------------------------------
  // N and the word are frozen for a whole symbol, so an input change
  // can never give one symbol two lengths or two different words
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      n_reg    <= {TONE_W{1'b0}};
      word_reg <= 16'h0000;
    end
    else if (sym_load)
    begin
      n_reg    <= tone_count_in;
      word_reg <= word_in;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // The FIFO decouples the IFFT stall from the tone sequencer; four words
  // cover the output stage latency so tones still stream at full rate
  utsm_fifo
  #(
    .WIDTH (TONE_W + 2),
    .DEPTH (`UTSM_FIFO_DEPTH),
    .AW    (2)
  )
  u_fifo
  (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .wdata_in   ({tone_reg, rot}),
    .wvalid_in  (emit),
    .wready_out (fifo_wready),
    .rdata_out  ({fifo_tone, fifo_point}),
    .rvalid_out (fifo_rvalid),
    .rready_in  (fifo_rd)
  );

  // Registered output stage so every output comes from a flop
  assign fifo_rd = fifo_rvalid & (~point_valid_out | point_ready_in);

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      point_out       <= 2'h0;
      tone_out        <= {TONE_W{1'b0}};
      point_valid_out <= 1'b0;
    end
    else if (~point_valid_out | point_ready_in)
    begin
      point_valid_out <= fifo_rvalid;
      if (fifo_rvalid)
      begin
        point_out <= fifo_point;
        tone_out  <= fifo_tone;
      end
    end
  end
endmodule // utsm_mapper
